// ### hw/cco_orient.sv
`timescale 1ns/1ns
// How it works
// - As source, pick data path from which CC pin the far sink terminates.
// - As sink, pick switch setting from which CC pin the far source pulls up.
// - Switch select steers TX and RX pairs onto connected position.
// - Pair group aligned with active CC is lane 0 and configuration lane.
// - The other pair group is lane 1.
// - Logical lanes are mapped onto physical pairs by this end.
// - All four straight/twisted, flipped/unflipped cases reduce to position 1 or 2.
// - Captive-cable devices need only the same two position cases.
// - Unworkable role pairing keeps VBUS and VCONN off.
// - Source-only works with sink or dual-role, never with source-only.
// - Sink-only works with source or dual-role, never with sink-only.
// - Two dual-role ports settle roles by toggling or by manual choice.
// - Detect first; later setup stages only after attach is reported.
// - Dual-role port alternates between source and sink presentation.
// - Source orientation comes from the CC pin seeing Rd.
// - Lane routing is set before VBUS is switched on.
// - On loss of Rd remove power, reset, and resume attach detection.
module cco_orient
    import cco_pkg::*;
(
    input  wire logic       ref_clk,     // 50 MHz clock
    input  wire logic       reset_n,     // Async reset, active low
    input  wire logic [1:0] port_cap,    // Own capability, cco_cap_t
    input  wire logic       drp_force,   // Manual role choice for dual-role
    input  wire logic       drp_pref_src,// Manual role: 1 source, 0 sink
    input  wire logic       cc1_rd,      // Pin: Rd seen on CC1 (as source) or Rp (as sink)
    input  wire logic       cc2_rd,      // Pin: same for CC2
    input  wire logic       cc1_ra,      // Pin: Ra seen on CC1 (source)
    input  wire logic       cc2_ra,      // Pin: Ra seen on CC2 (source)
    output logic            present_src, // Present Rp (1) or Rd (0)
    output logic [1:0]      lane_sel,    // 0 none, 1 position 1, 2 position 2
    output logic            lane0_pos2,  // Lane 0 on position 2 pairs
    output logic            vbus_en,     // Apply VBUS
    output logic            vconn_en,    // Apply VCONN
    output logic            vconn_cc2,   // VCONN on CC2 (else CC1)
    output logic            attached,    // Attach done, setup may continue
    output logic            is_source    // Settled role
);
    typedef enum logic [2:0] {
        ST_TOGGLE, ST_SRC_ROUTE, ST_SRC_ON, ST_SNK_ON
    } cco_state_t;

    typedef struct packed {
        cco_state_t       st;
        logic             src;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       sel;
        logic             l0p2;
        logic             vbus;
        logic             vconn;
        logic             vc2;
        logic             att;
        logic             isrc;
    } cco_st_t;

    cco_st_t r;
    cco_st_t next_r;
    cco_sense_if sense ();

    cco_sync u_sync (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .cc1_in    (cc1_rd),
        .cc2_in    (cc2_rd),
        .cc1_ra_in (cc1_ra),
        .cc2_ra_in (cc2_ra),
        .sense     (sense)
    );

    // Exactly one terminated pin gives a position; both or none give none
    function automatic logic [1:0] pos_of(input logic a, input logic b);
        if (a && !b) begin
            pos_of = SEL_POS1;
        end else if (b && !a) begin
            pos_of = SEL_POS2;
        end else begin
            pos_of = SEL_NONE;
        end
    endfunction

    logic [1:0] pos;
    logic       can_src;
    logic       can_snk;
    logic       toggling;

    always_comb begin
        pos     = pos_of(sense.cc1_term, sense.cc2_term);
        // Source-only never presents Rd, sink-only never Rp, so like pairs stay idle
        can_src = (port_cap != CCO_CAP_SNK);
        can_snk = (port_cap != CCO_CAP_SRC);
        toggling = (port_cap == CCO_CAP_DRP) && !drp_force;
        next_r  = r;
        case (r.st)
            ST_TOGGLE: begin
                next_r.sel   = SEL_NONE;
                next_r.vbus  = 1'b0;
                next_r.vconn = 1'b0;
                next_r.att   = 1'b0;
                if (toggling) begin
                    if (r.cnt >= CNT_W'(DRP_HALF_CYC - 1)) begin
                        next_r.cnt = '0;
                        next_r.src = !r.src;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end else begin
                    next_r.cnt = '0;
                    next_r.src = (port_cap == CCO_CAP_DRP) ? drp_pref_src : can_src;
                end
                // Pins still show the old role just after a flip, so skip them briefly
                if (pos != SEL_NONE && (r.src ? can_src : can_snk)
                        && !(toggling && r.cnt < CNT_W'(SYNC_LAT_CYC))) begin
                    // Attach in the role the far end answered, not a flip of this edge
                    next_r.src  = r.src;
                    next_r.sel  = pos;
                    next_r.l0p2 = (pos == SEL_POS2);
                    next_r.vc2  = (pos == SEL_POS1);
                    next_r.cnt  = '0;
                    next_r.st   = r.src ? ST_SRC_ROUTE : ST_SNK_ON;
                    next_r.att  = !r.src;
                end
            end
            ST_SRC_ROUTE: begin
                if (pos != r.sel) begin
                    next_r.st  = ST_TOGGLE;
                    next_r.sel = SEL_NONE;
                    next_r.cnt = '0;
                end else if (r.cnt >= CNT_W'(ROUTE_SETTLE_CYC - 1)) begin
                    next_r.st    = ST_SRC_ON;
                    next_r.vbus  = 1'b1;
                    next_r.vconn = r.vc2 ? sense.cc2_ra : sense.cc1_ra;
                    next_r.att   = 1'b1;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            ST_SRC_ON, ST_SNK_ON: begin
                // Select frozen while attached; any loss of the routed pin is detach
                if (pos != r.sel) begin
                    next_r.st    = ST_TOGGLE;
                    next_r.sel   = SEL_NONE;
                    next_r.vbus  = 1'b0;
                    next_r.vconn = 1'b0;
                    next_r.att   = 1'b0;
                    next_r.cnt   = '0;
                end
            end
            default: begin
                next_r.st = ST_TOGGLE;
            end
        endcase
        next_r.isrc = (next_r.st == ST_SRC_ROUTE) || (next_r.st == ST_SRC_ON);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{st: ST_TOGGLE, sel: SEL_NONE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign present_src = r.src;
    assign lane_sel    = r.sel;
    assign lane0_pos2  = r.l0p2;
    assign vbus_en     = r.vbus;
    assign vconn_en    = r.vconn;
    assign vconn_cc2   = r.vc2;
    assign attached    = r.att;
    assign is_source   = r.isrc;
endmodule

// ### hw/cco_pkg.sv
package cco_pkg;
    localparam int CLK_HZ = 50_000_000;
    // DRP toggle half period in microseconds
    localparam int DRP_HALF_US  = 50;
    localparam int DRP_HALF_CYC = CLK_HZ / 1_000_000 * DRP_HALF_US;
    // Hold between lane routing settle and power enable, in cycles
    localparam int ROUTE_SETTLE_CYC = 4;
    // Cycles the synchronised pins lag a change of presented role
    localparam int SYNC_LAT_CYC = 2;
    localparam int CNT_W = 16;

    // Port capability
    typedef enum logic [1:0] {
        CCO_CAP_SRC = 2'd0,
        CCO_CAP_SNK = 2'd1,
        CCO_CAP_DRP = 2'd2
    } cco_cap_t;

    // Lane select values
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_POS1 = 2'h1;
    localparam logic [1:0] SEL_POS2 = 2'h2;
endpackage

// ### hw/cco_sense_if.sv
`timescale 1ns/1ns
interface cco_sense_if;
    logic cc1_term;
    logic cc2_term;
    logic cc1_ra;
    logic cc2_ra;
    modport sync (output cc1_term, output cc2_term, output cc1_ra, output cc2_ra);
    modport core (input cc1_term, input cc2_term, input cc1_ra, input cc2_ra);
endinterface

// ### hw/cco_sync.sv
`timescale 1ns/1ns
module cco_sync
    import cco_pkg::*;
(
    input  wire logic    ref_clk,   // System clock
    input  wire logic    reset_n,   // Async reset
    input  wire logic    cc1_in,    // CC1 far termination seen
    input  wire logic    cc2_in,    // CC2 far termination seen
    input  wire logic    cc1_ra_in, // CC1 shows Ra
    input  wire logic    cc2_ra_in, // CC2 shows Ra
    cco_sense_if.sync    sense      // Synchronised sense
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
    } cco_sync_st_t;

    cco_sync_st_t r;
    cco_sync_st_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = {cc2_ra_in, cc1_ra_in, cc2_in, cc1_in};
        next_r.s2 = r.s1;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sense.cc1_term = r.s2[0];
    assign sense.cc2_term = r.s2[1];
    assign sense.cc1_ra   = r.s2[2];
    assign sense.cc2_ra   = r.s2[3];
endmodule

// ### test/cco_orient_assertions.sv
`timescale 1ns/1ns
module cco_orient_assertions
    import cco_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset_n,
    input wire logic [1:0] port_cap,
    input wire logic       drp_force,
    input wire logic       cc1_rd,
    input wire logic       cc2_rd,
    input wire logic [1:0] lane_sel,
    input wire logic       lane0_pos2,
    input wire logic       vbus_en,
    input wire logic       vconn_en,
    input wire logic       attached,
    input wire logic       is_source,
    input wire logic       present_src
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic [CNT_W-1:0] hold;
    logic             src_q;
    // Cycles since the dual-role end last changed its presentation or was attached
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hold  <= '0;
            src_q <= 1'b0;
        end else begin
            src_q <= present_src;
            if (attached || present_src != src_q) begin
                hold <= '0;
            end else begin
                hold <= hold + 1'b1;
            end
        end
    end
    property p_route; vbus_en |-> lane_sel != SEL_NONE; endproperty
    a_route: assert property (p_route) else $error("power unrouted");
    property p_settle; $rose(vbus_en) |-> $past(lane_sel, 4) != SEL_NONE; endproperty
    a_settle: assert property (p_settle) else $error("route late");
    property p_pin;
        lane_sel != SEL_NONE |-> ($past(cc1_rd, 3) != $past(cc2_rd, 3))
            && ((lane_sel == SEL_POS2) == $past(cc2_rd, 3));
    endproperty
    a_pin: assert property (p_pin) else $error("wrong pin");
    property p_lane; lane_sel != SEL_NONE |-> lane0_pos2 == (lane_sel == SEL_POS2); endproperty
    a_lane: assert property (p_lane) else $error("lane order");
    property p_detach;
        lane_sel != SEL_NONE && !cc1_rd && !cc2_rd |-> ##[1:4] (lane_sel == SEL_NONE && !vbus_en);
    endproperty
    a_detach: assert property (p_detach) else $error("no detach");
    property p_snk; port_cap == CCO_CAP_SNK |-> !vbus_en && !vconn_en; endproperty
    a_snk: assert property (p_snk) else $error("sink powers");
    property p_src; port_cap == CCO_CAP_SRC |-> ##[1:2] present_src; endproperty
    a_src: assert property (p_src) else $error("source role");
    property p_order; vbus_en |-> attached && is_source; endproperty
    a_order: assert property (p_order) else $error("power order");
    property p_vconn; vconn_en |-> vbus_en; endproperty
    a_vconn: assert property (p_vconn) else $error("vconn alone");
    property p_drp; port_cap == CCO_CAP_DRP && !drp_force |-> hold <= DRP_HALF_CYC + 2; endproperty
    a_drp: assert property (p_drp) else $error("no toggle");
    cover property (vbus_en && vconn_en);
    cover property (lane_sel == SEL_POS2 && attached);
    cover property (attached && !is_source);
endmodule
bind cco_orient cco_orient_assertions cco_orient_assertions_inst (.ref_clk, .reset_n,
    .port_cap, .drp_force, .cc1_rd, .cc2_rd, .lane_sel, .lane0_pos2, .vbus_en,
    .vconn_en, .attached, .is_source, .present_src);

// ### test/cco_far_port.sv
`timescale 1ns/1ns
module cco_far_port
    import cco_pkg::*;
(
    input  wire logic       ref_clk,  // Clock
    input  wire logic       plugged,  // Cable in
    input  wire logic       pos2,     // Far CC lands on position 2
    input  wire logic       powered,  // Cable shows Ra
    input  wire logic [1:0] far_cap,  // Far capability
    input  wire logic       near_src, // Near end presents Rp
    output logic            cc1_rd,   // Far term on CC1
    output logic            cc2_rd,   // Far term on CC2
    output logic            cc1_ra,   // Ra on CC1
    output logic            cc2_ra    // Ra on CC2
);
    logic        far_src = 1'b0;
    logic [11:0] tgl = '0;
    logic        term;
    // Period unlike the near end so two toggling ends cannot stay in step
    always @(posedge ref_clk) begin
        tgl <= tgl + 1'b1;
        if (far_cap != CCO_CAP_DRP)
            far_src <= (far_cap == CCO_CAP_SRC);
        else if (!(plugged && far_src != near_src) && tgl >= 12'd1700) begin
            far_src <= !far_src;
            tgl <= '0;
        end
    end
    assign term = plugged && (far_src != near_src);
    assign cc1_rd = term && !pos2;
    assign cc2_rd = term && pos2;
    assign cc1_ra = plugged && powered && pos2;
    assign cc2_ra = plugged && powered && !pos2;
endmodule

// ### test/cco_orientation_lane_routing_test.sv
`timescale 1ns/1ns
module cco_orientation_lane_routing_test;
    import cco_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, drp_force = 1'b0, drp_pref_src = 1'b0;
    logic plugged = 1'b0, pos2 = 1'b0, powered = 1'b0;
    logic [1:0] port_cap = 2'h0, far_cap = 2'h1, lane_sel;
    logic cc1_rd, cc2_rd, cc1_ra, cc2_ra, present_src, lane0_pos2;
    logic vbus_en, vconn_en, vconn_cc2, attached, is_source;
    int n_fail = 0, tests_run = 0;
    cco_orient cco_orient_inst (.ref_clk, .reset_n, .port_cap, .drp_force, .drp_pref_src,
        .cc1_rd, .cc2_rd, .cc1_ra, .cc2_ra, .present_src, .lane_sel, .lane0_pos2,
        .vbus_en, .vconn_en, .vconn_cc2, .attached, .is_source);
    cco_far_port cco_far_port_inst (.ref_clk, .plugged, .pos2, .powered, .far_cap,
        .near_src(present_src), .cc1_rd, .cc2_rd, .cc1_ra, .cc2_ra);
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic restart(input logic [1:0] cap, input logic [1:0] fcap, input logic [1:0] md);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        plugged <= 1'b0;
        port_cap <= cap;
        far_cap <= fcap;
        {drp_force, drp_pref_src} <= md;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask
    task automatic attach(input logic p, input logic r, input int lim);
        @(posedge ref_clk);
        plugged <= 1'b1;
        pos2 <= p;
        powered <= r;
        for (int i = 0; i < lim && attached !== 1'b1; i++) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic t_host();
        logic p;
        for (int i = 0; i < 4; i++) begin
            p = i[0] ^ i[1];
            restart(CCO_CAP_SRC, CCO_CAP_SNK, 2'b00);
            attach(p, i[0], 30);
            chk(lane_sel, p ? SEL_POS2 : SEL_POS1);
            chk(lane0_pos2, p);
            chk({vbus_en, vconn_en, vconn_cc2}, {1'b1, i[0], !p});
            chk(present_src, 1'b1);
            @(posedge ref_clk);
            plugged <= 1'b0;
            repeat (5) @(negedge ref_clk);
            chk({lane_sel, vbus_en, vconn_en, attached}, 8'h00);
        end
    endtask
    task automatic t_dev();
        logic s;
        // Sink with source, sink with dual-role, source with dual-role
        for (int k = 0; k < 3; k++) begin
            s = (k == 2);
            restart(s ? CCO_CAP_SRC : CCO_CAP_SNK, k == 0 ? CCO_CAP_SRC : CCO_CAP_DRP, 2'b00);
            attach(!s, 1'b0, 2000);
            chk(lane_sel, s ? SEL_POS1 : SEL_POS2);
            chk({vbus_en, is_source, attached}, {s, s, 1'b1});
            @(posedge ref_clk);
            plugged <= 1'b0;
            repeat (5) @(negedge ref_clk);
            chk({lane_sel, vbus_en, attached}, 8'h00);
        end
    endtask
    task automatic t_like();
        for (int k = 0; k < 2; k++) begin
            restart(k[1:0], k[1:0], 2'b00);
            attach(1'b0, 1'b1, 60);
            chk({lane_sel, vbus_en, vconn_en, attached}, 8'h00);
            chk(present_src, k == 0);
        end
    endtask
    task automatic t_drp();
        for (int m = 0; m < 3; m++) begin
            restart(CCO_CAP_DRP, CCO_CAP_DRP, m > 0 ? {1'b1, m[1]} : 2'b00);
            attach(1'b0, 1'b0, 12000);
            chk(attached, 1'b1);
            if (m > 0)
                chk(is_source, m[1]);
        end
    endtask
    initial begin
        for (int c = 0; c < 40000; c++) @(posedge ref_clk);
        n_fail++;
        finish_test();
    end
    initial begin
        t_host();
        t_dev();
        t_like();
        t_drp();
        finish_test();
    end
endmodule
